/* File: design/sar_adc_serial_readout.sv */
/*
 * digital control and serial readout of an 18-bit successive
 * approximation converter: conversion sequencer on the internal
 * oscillator clock, result shifter on the host serial clock.
 * assumes an analog core that samples while acquire is high, drives a
 * comparator level from the held sample against dac_code, and a host
 * that keeps the serial clock still while busy is high.
 */

// ********************************************************************
// sar_adc_serial_readout
// ********************************************************************

// Contract
// - convert edge wakes device, starts conversion
// - busy high during conversion, low after
// - daisy low: shared pin enables output
// - daisy high: shared pin is chain input
// - one bit per sck rise, msb first
// - result is two's complement
// - conversion end assembles 18-bit output code
// - bipolar zero gives all zeros code
// - eighteen successive approximation steps, msb down
// - acquisition alternates with conversion phase
// - conversion timed by internal clock only
// - readout is own result, no latency
// - automatic nap after each conversion
// - output released quickly when enable rises
// - first bit valid when busy falls
module sar_adc_serial_readout #(
    parameter int RES_W   = sar_pkg::RES_W,
    parameter int BIT_CYC = sar_pkg::BIT_CYC
) (
    // internal oscillator clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // host control pins
    input  wire logic            convert_start_input,
    input  wire logic            daisy_select,
    input  wire logic            read_enable_or_chain_input,
    // host serial clock
    input  wire logic            sck,
    // analog core
    input  wire logic            cmp_above,
    output logic [RES_W-1:0]     dac_code,
    // status
    output sar_pkg::sar_status_t status,
    // serial data pin
    output sar_pkg::sar_sdo_t    sdo
);

    // ****************************************************************
    // local sizes and helpers
    // ****************************************************************

    localparam int STEP_W = $clog2(BIT_CYC + 1);
    localparam int IDX_W  = $clog2(RES_W);
    localparam int N_PIN  = 3;

    // one-hot weight of a trial bit
    function automatic logic [RES_W-1:0] bit_mask(
        input logic [IDX_W-1:0] idx
    );
        logic [RES_W-1:0] m;
        m      = '0;
        m[idx] = 1'b1;
        return m;
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************

    // pin synchronisers: 0 convert, 1 daisy select, 2 comparator
    logic [N_PIN-1:0]    pin_raw;
    logic [N_PIN-1:0]    pin_meta_q;
    logic [N_PIN-1:0]    pin_sync_q;

    logic                conv_prev_q;
    logic                start_pulse;
    logic                chain_mode;
    logic                cmp_level;

    sar_pkg::sar_state_t state_q;
    sar_pkg::sar_state_t state_d;

    logic [STEP_W-1:0]   step_q;
    logic                step_last;
    logic [IDX_W-1:0]    bit_q;
    logic                bit_last;
    logic                conv_done;

    logic [RES_W-1:0]    trial_q;
    logic [RES_W-1:0]    kept;
    logic [RES_W-1:0]    result_q;

    logic                busy_q;
    logic                busy_d;
    logic                hold_q;
    logic                nap_q;

    // serial clock domain
    logic                first_done_q;
    logic [RES_W-1:0]    shreg_q;
    logic                sdi_bit;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************

    assign pin_raw = {cmp_above, daisy_select, convert_start_input};

    // two flops per asynchronous pin
    genvar gi;
    generate
        for (gi = 0; gi < N_PIN; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (rst) begin
                    pin_meta_q[gi] <= 1'b0;
                    pin_sync_q[gi] <= 1'b0;
                end else begin
                    pin_meta_q[gi] <= pin_raw[gi];
                    pin_sync_q[gi] <= pin_meta_q[gi];
                end
            end
        end
    endgenerate

    // previous convert level for edge detection
    always_ff @(posedge mclk) begin
        if (rst) begin
            conv_prev_q <= 1'b0;
        end else begin
            conv_prev_q <= pin_sync_q[0];
        end
    end

    // rising convert edge only counts while acquiring
    assign start_pulse = pin_sync_q[0] & ~conv_prev_q
                         & (state_q == sar_pkg::SAR_ST_ACQ);
    assign chain_mode  = pin_sync_q[1];
    assign cmp_level   = pin_sync_q[2];

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************

    // step and bit position decode
    assign step_last = (step_q == STEP_W'(BIT_CYC - 1));
    assign bit_last  = (bit_q == '0);
    assign conv_done = (state_q == sar_pkg::SAR_ST_CONV)
                       & step_last & bit_last;

    // next state: acquire until an edge, convert until the lsb is done
    always_comb begin
        state_d = state_q;
        case (state_q)
            sar_pkg::SAR_ST_ACQ: begin
                if (start_pulse) begin
                    state_d = sar_pkg::SAR_ST_CONV;
                end
            end
            sar_pkg::SAR_ST_CONV: begin
                if (conv_done) begin
                    state_d = sar_pkg::SAR_ST_ACQ;
                end
            end
            default: begin
                state_d = sar_pkg::SAR_ST_ACQ;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= sar_pkg::SAR_ST_ACQ;
        end else begin
            state_q <= state_d;
        end
    end

    // cycles within one trial bit, from the internal clock
    always_ff @(posedge mclk) begin
        if (rst || start_pulse) begin
            step_q <= '0;
        end else if (state_q == sar_pkg::SAR_ST_CONV) begin
            if (step_last) begin
                step_q <= '0;
            end else begin
                step_q <= step_q + STEP_W'(1);
            end
        end
    end

    // trial bit index walks from msb down to lsb
    always_ff @(posedge mclk) begin
        if (rst) begin
            bit_q <= '0;
        end else if (start_pulse) begin
            bit_q <= IDX_W'(RES_W - 1);
        end else if (state_q == sar_pkg::SAR_ST_CONV
                     && step_last && !bit_last) begin
            bit_q <= bit_q - IDX_W'(1);
        end
    end

    // keep the trial bit when the sample is above the dac level
    assign kept = cmp_level ? trial_q : (trial_q & ~bit_mask(bit_q));

    // successive approximation register, offset binary
    always_ff @(posedge mclk) begin
        if (rst) begin
            trial_q <= sar_pkg::TRIAL_RST;
        end else if (start_pulse) begin
            trial_q <= bit_mask(IDX_W'(RES_W - 1));
        end else if (state_q == sar_pkg::SAR_ST_CONV && step_last) begin
            if (bit_last) begin
                trial_q <= kept;
            end else begin
                trial_q <= kept | bit_mask(bit_q - IDX_W'(1));
            end
        end
    end

    // result: msb flipped turns offset binary into two's complement
    always_ff @(posedge mclk) begin
        if (rst) begin
            result_q <= sar_pkg::RESULT_RST;
        end else if (conv_done) begin
            result_q <= kept ^ bit_mask(IDX_W'(RES_W - 1));
        end
    end

    // ****************************************************************
    // busy, nap and serial hold
    // ****************************************************************

    // busy rises with the start and falls with the result load
    always_comb begin
        busy_d = busy_q;
        if (start_pulse) begin
            busy_d = 1'b1;
        end else if (conv_done) begin
            busy_d = 1'b0;
        end
    end

    // busy register
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy_d;
        end
    end

    // holds the serial side cleared in reset and while converting
    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_q <= 1'b1;
        end else begin
            hold_q <= busy_d;
        end
    end

    // nap between conversions, no host command needed
    always_ff @(posedge mclk) begin
        if (rst) begin
            nap_q <= 1'b1;
        end else if (start_pulse) begin
            nap_q <= 1'b0;
        end else if (conv_done) begin
            nap_q <= 1'b1;
        end
    end

    // ****************************************************************
    // serial shifter on the host clock
    // ****************************************************************

    // chain input only in chain mode; normal mode shifts in zeros
    assign sdi_bit = chain_mode & read_enable_or_chain_input;

    // result is static while busy is low; hold_q clears this side
    // asynchronously, the host keeps sck still around that release
    always_ff @(posedge sck or posedge hold_q) begin
        if (hold_q) begin
            first_done_q <= 1'b0;
            shreg_q      <= '0;
        end else begin
            first_done_q <= 1'b1;
            if (!first_done_q) begin
                shreg_q <= {result_q[RES_W-2:0], sdi_bit};
            end else begin
                shreg_q <= {shreg_q[RES_W-2:0], sdi_bit};
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    // msb straight from the result until the first sck rise
    assign sdo.data = first_done_q ? shreg_q[RES_W-1]
                                   : result_q[RES_W-1];

    // pad gate: normal mode follows the active-low enable directly
    assign sdo.oe = chain_mode | ~read_enable_or_chain_input;

    // analog core and host status
    assign dac_code       = trial_q;
    assign status.busy    = busy_q;
    assign status.nap     = nap_q;
    assign status.acquire = (state_q == sar_pkg::SAR_ST_ACQ);

endmodule // sar_adc_serial_readout

/* File: include/sar_pkg.sv */
/*
 * shared constants and types for the sar converter control block.
 * assumes the control clock runs at 100 mhz; the conversion timing is
 * derived from that rate and the least conversion time.
 */

// ********************************************************************
// sar_pkg
// ********************************************************************
package sar_pkg;

    // result width and bit positions
    localparam int RES_W = 18;
    localparam int MSB_POS = RES_W - 1;

    // control clock period
    localparam int CLK_PERIOD_NS = 10;

    // least conversion time, rounded up to whole cycles
    localparam int CONV_TIME_NS = 1000;
    localparam int CONV_CYC =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // cycles spent on each trial bit (comparator settle plus sync)
    localparam int BIT_CYC = (CONV_CYC + RES_W - 1) / RES_W;

    // reset values
    localparam logic [17:0] RESULT_RST = 18'h00000;
    localparam logic [17:0] TRIAL_RST  = 18'h00000;

    // conversion sequencer states
    typedef enum logic [0:0] {
        SAR_ST_ACQ  = 1'b0,
        SAR_ST_CONV = 1'b1
    } sar_state_t;

    // status pins toward the host and the analog core
    typedef struct packed {
        logic busy;
        logic nap;
        logic acquire;
    } sar_status_t;

    // serial data pin: level and output enable
    typedef struct packed {
        logic data;
        logic oe;
    } sar_sdo_t;

endpackage

/* File: tb/sar_host.sv */
/* host controller model: convert pulses and serial frames.
   assumes mclk from the bench; link clock made here, 48 ns. */
// ****
// sar_host
// ****
module sar_host (
    // clock and device side
    input  wire logic                 mclk,
    input  wire sar_pkg::sar_status_t status,
    input  wire sar_pkg::sar_sdo_t    sdo,
    // host pins
    output logic                      convert_start_input,
    output logic                      sck,
    output logic                      read_enable_or_chain_input
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle pins; link clock stands low outside frames
    initial begin
        convert_start_input = 1'b0;
        sck = 1'b0;
        read_enable_or_chain_input = 1'b1;
    end
    // convert pulse: 30 ns high, then 30 ns low and quiet
    task automatic convert();
        @(negedge mclk) convert_start_input = 1'b1;
        repeat (3) @(negedge mclk);
        convert_start_input = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    // one frame of n bits; chain input fed msb first
    task automatic frame(input int n, input logic chain,
                         input logic [17:0] din, output logic [35:0] dout);
        int i;
        dout = 36'h0;
        for (i = 0; i < 300 && status.busy !== 1'b0; i++) #10;
        // offset keeps frame edges away from the control clock edges
        #8;
        for (i = 0; i < n; i++) begin
            read_enable_or_chain_input = chain && i < 18 && din[17-i];
            // a released pad reads as the inverse of its level
            #12 dout = {dout[34:0], sdo.oe ? sdo.data : ~sdo.data};
            #12 sck = 1'b1;
            #24 sck = 1'b0;
        end
        // released chain line shows the inverse of its last bit
        read_enable_or_chain_input = ~read_enable_or_chain_input;
    endtask
endmodule // sar_host

/* File: tb/sar_readout_checker.sv */
/* assertions on the converter control block ports.
   bound into the top module; one clock domain is watched. */
// ****
// sar_readout_checker
// ****
module sar_readout_checker #(
    parameter int RES_W   = sar_pkg::RES_W,
    parameter int BIT_CYC = sar_pkg::BIT_CYC
) (
    // clock and reset
    input wire logic                 mclk,
    input wire logic                 rst,
    // host pins
    input wire logic                 convert_start_input,
    input wire logic                 daisy_select,
    input wire logic                 read_enable_or_chain_input,
    input wire logic                 sck,
    // analog core
    input wire logic                 cmp_above,
    input wire logic [RES_W-1:0]     dac_code,
    // status and serial pin
    input wire sar_pkg::sar_status_t status,
    input wire sar_pkg::sar_sdo_t    sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // cycles spent busy in this conversion
    logic [8:0] busy_q;
    always_ff @(posedge mclk) begin
        if (rst || !status.busy) busy_q <= 9'h000;
        else busy_q <= busy_q + 9'h001;
    end
    start_on_edge_a: assert property (
        $rose(convert_start_input) && !status.busy |-> ##[2:4] status.busy)
        else $error("busy missing after convert edge");
    busy_length_a: assert property (
        $fell(status.busy) |-> busy_q == 9'(18 * BIT_CYC))
        else $error("conversion length wrong");
    busy_bound_a: assert property (
        busy_q <= 9'(18 * BIT_CYC))
        else $error("conversion overran");
    nap_state_a: assert property (
        status.nap == !status.busy)
        else $error("nap not opposite busy");
    acquire_phase_a: assert property (
        status.acquire == !status.busy)
        else $error("acquire not opposite busy");
    trial_msb_a: assert property (
        $rose(status.busy) |-> dac_code == 18'h20000)
        else $error("first trial code wrong");
    trial_step_a: assert property (
        $rose(status.busy) |-> (dac_code[16:0] == 17'h00000)[*6]
        ##1 dac_code[16])
        else $error("second trial bit late");
    oe_normal_a: assert property (
        !daisy_select && !$past(daisy_select, 3)
        |-> sdo.oe == !read_enable_or_chain_input)
        else $error("output enable wrong in normal mode");
    oe_chain_a: assert property (
        daisy_select && $past(daisy_select, 3) |-> sdo.oe)
        else $error("output enable low in chain mode");
endmodule // sar_readout_checker

bind sar_adc_serial_readout sar_readout_checker #(
    .RES_W(RES_W), .BIT_CYC(BIT_CYC)
) u_chk (
    .mclk, .rst, .convert_start_input, .daisy_select, .sck, .cmp_above,
    .read_enable_or_chain_input, .dac_code, .status, .sdo
);

/* File: tb/tb_sar_adc_serial_readout.sv */
/* self-checking bench for the converter control block.
   assumes the package, the host model and the bound checker. */
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
// ****
// tb_sar_adc_serial_readout
// ****
module tb_sar_adc_serial_readout;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 mclk;
    logic                 rst;
    logic                 daisy_select;
    logic                 convert_start_input;
    logic                 sck;
    logic                 read_enable_or_chain_input;
    logic                 cmp_above;
    logic [17:0]          vin;
    logic [17:0]          dac_code;
    sar_pkg::sar_status_t status;
    sar_pkg::sar_sdo_t    sdo;
    logic [35:0]          dout;
    int                   fail_count;
    int                   n_checks;
    // 100 mhz control clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // held sample compared against the trial code
    assign cmp_above = (vin >= dac_code);
    sar_adc_serial_readout uut (
        .mclk, .rst, .convert_start_input, .daisy_select, .sck, .cmp_above,
        .read_enable_or_chain_input, .dac_code, .status, .sdo
    );
    sar_host host (
        .mclk, .status, .sdo, .convert_start_input, .sck,
        .read_enable_or_chain_input
    );
    // verdict and end of run
    task automatic tally_and_finish();
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // idle state after reset
    task automatic t_reset();
        @(negedge mclk);
        `CHK(status, 3'b011)
        `CHK(sdo.data, 1'b0)
    endtask
    // codes across the range, read back to back
    task automatic t_codes();
        logic [17:0] v [5];
        v = '{18'h20000, 18'h1ffff, 18'h3ffff, 18'h00000, 18'h2a5c3};
        foreach (v[i]) begin
            @(negedge mclk);
            vin = v[i];
            host.convert();
            host.frame(36, 1'b0, 18'h0, dout);
            `CHK(dout[35:18], v[i] ^ 18'h20000)
            `CHK(dout[17:0], 18'h0)
        end
    endtask
    // enable pin gates the serial output in normal mode
    task automatic t_enable();
        @(negedge mclk);
        `CHK(sdo.oe, 1'b0)
        host.read_enable_or_chain_input = 1'b0;
        #1 `CHK(sdo.oe, 1'b1)
        host.read_enable_or_chain_input = 1'b1;
        #1 `CHK(sdo.oe, 1'b0)
    endtask
    // a second convert edge during busy is not queued
    task automatic t_refuse();
        @(negedge mclk);
        vin = 18'h155aa;
        host.convert();
        repeat (20) @(negedge mclk);
        host.convert();
        host.frame(18, 1'b0, 18'h0, dout);
        `CHK(dout[17:0], 18'h355aa)
        `CHK(status.busy, 1'b0)
    endtask
    // chain mode: own result, then forwarded chain bits
    task automatic t_chain();
        @(negedge mclk);
        daisy_select = 1'b1;
        repeat (5) @(negedge mclk);
        `CHK(sdo.oe, 1'b1)
        vin = 18'h3ffff;
        host.convert();
        host.frame(36, 1'b1, 18'h2d1c7, dout);
        `CHK(dout, {18'h1ffff, 18'h2d1c7})
        @(negedge mclk);
        daisy_select = 1'b0;
        repeat (5) @(negedge mclk);
    endtask
    // main sequence
    initial begin
        fail_count = 0;
        n_checks = 0;
        rst = 1'b1;
        daisy_select = 1'b0;
        vin = 18'h20000;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        t_reset();
        t_codes();
        t_enable();
        t_refuse();
        t_chain();
        tally_and_finish();
    end
    // watchdog, several times the expected run
    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end
endmodule // tb_sar_adc_serial_readout
